// ===== common/eapi_pkg.sv
package eapi_pkg;

	// Deglitch hold count in mclk cycles
	localparam int unsigned DEGLITCH_CYCLES = 4;
	localparam int unsigned DEGLITCH_CW     = 3;

	// Values after reset
	localparam logic        RUN_RESET      = 1'b0;
	localparam logic        BOOT_RESET     = 1'b1;
	localparam logic        FILT_RESET_HI  = 1'b1;

	typedef enum logic [1:0] {
		EAPI_ST_STANDBY = 2'b01,
		EAPI_ST_RUN     = 2'b10
	} eapi_state_t;

	// Requests towards the processor and state control
	typedef struct packed {
		logic       fast_irq;
		logic [1:0] normal_irq;
		logic       enter_standby;
		logic       leave_blocked;
	} eapi_req_t;

endpackage

// ===== rtl/eapi_deglitch.sv
`timescale 1ns/100ps
module eapi_deglitch #(
	parameter int unsigned HOLD = eapi_pkg::DEGLITCH_CYCLES,
	parameter int unsigned CW   = eapi_pkg::DEGLITCH_CW
) (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic raw,
	output logic      clean_r
);
	logic [CW-1:0] cnt_r;

	// Level accepted only after HOLD equal samples
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_r   <= '0;
			clean_r <= eapi_pkg::FILT_RESET_HI;
		end
		else if (raw == clean_r)
			cnt_r <= '0;
		else if (cnt_r == CW'(HOLD - 1))
		begin
			cnt_r   <= '0;
			clean_r <= raw;
		end
		else
			cnt_r <= cnt_r + 1'b1;
	end

	hold_a: assert property (@(posedge mclk) disable iff (!rstn)
		$changed(clean_r) |-> $past(raw, 1) == clean_r)
		else $error("Filter changed without matching input");
endmodule

// ===== rtl/eapi_top.sv
`timescale 1ns/100ps
module eapi_top #(
	parameter int unsigned HOLD = eapi_pkg::DEGLITCH_CYCLES
) (
	input  wire logic          mclk,
	input  wire logic          rstn,
	input  wire logic          media_change_irq_n,
	input  wire logic          ext_fast_irq_n,
	input  wire logic [1:0]    ext_general_irq_n,
	input  wire logic          power_fail_n,
	input  wire logic          main_battery_good,
	input  wire logic          external_supply_sense_n,
	input  wire logic          wake_req,
	input  wire logic          standby_req,
	output eapi_pkg::eapi_req_t req_r,
	output logic               run_r,
	output logic               boot_rom_select_n,
	output logic               on_external_supply_r
);
	// =====================================================
	// Deglitch filters
	logic [2:0] raw;
	logic [2:0] clean;
	assign raw = {main_battery_good, power_fail_n, media_change_irq_n};

	for (genvar i = 0; i < 3; i++)
	begin : g_flt
		eapi_deglitch #(.HOLD(HOLD), .CW(eapi_pkg::DEGLITCH_CW)) u_flt (
			.mclk    (mclk),
			.rstn    (rstn),
			.raw     (raw[i]),
			.clean_r (clean[i])
		);
	end

	logic media_ok;
	logic pfail_ok;
	logic batt_ok;
	assign media_ok = clean[0];
	assign pfail_ok = clean[1];
	assign batt_ok  = clean[2];

	// =====================================================
	// Boot strap, caught once after reset release
	// Raw pin on purpose: no filter could settle this early
	logic strap_done_r;
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			strap_done_r      <= 1'b0;
			boot_rom_select_n <= eapi_pkg::BOOT_RESET;
		end
		else if (!strap_done_r)
		begin
			strap_done_r      <= 1'b1;
			boot_rom_select_n <= media_change_irq_n;
		end
	end

	// =====================================================
	// Battery edge detection
	// Delay resets high like the filter, so no false edge after reset
	logic batt_d_r;
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			batt_d_r <= eapi_pkg::FILT_RESET_HI;
		else
			batt_d_r <= batt_ok;
	end
	logic batt_fall;
	assign batt_fall = batt_d_r & ~batt_ok;

	// =====================================================
	// Power state
	eapi_pkg::eapi_state_t st_r;
	eapi_pkg::eapi_state_t st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			eapi_pkg::EAPI_ST_STANDBY:
				if (wake_req && batt_ok && pfail_ok)
					st_nxt = eapi_pkg::EAPI_ST_RUN;
			eapi_pkg::EAPI_ST_RUN:
				if (!pfail_ok || standby_req)
					st_nxt = eapi_pkg::EAPI_ST_STANDBY;
			default:
				st_nxt = eapi_pkg::EAPI_ST_STANDBY;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r  <= eapi_pkg::EAPI_ST_STANDBY;
			run_r <= eapi_pkg::RUN_RESET;
		end
		else
		begin
			st_r  <= st_nxt;
			run_r <= (st_nxt == eapi_pkg::EAPI_ST_RUN);
		end
	end

	// =====================================================
	// Requests; in standby the interrupt sources are quiet
	logic running;
	assign running = (st_r == eapi_pkg::EAPI_ST_RUN);

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			req_r                <= '0;
			on_external_supply_r <= 1'b0;
		end
		else
		begin
			req_r.fast_irq <= running & (~media_ok | ~ext_fast_irq_n | batt_fall);
			req_r.normal_irq    <= {2{running}} & ~ext_general_irq_n;
			req_r.enter_standby <= ~pfail_ok;
			req_r.leave_blocked <= ~running & ~batt_ok;
			// Board keeps this low on external power
			on_external_supply_r <= ~external_supply_sense_n;
		end
	end

	// =====================================================
	// Checks
	sequence fail_seen_s;
		!pfail_ok;
	endsequence
	sequence standby_after_s;
		##1 !run_r;
	endsequence

	pfail_standby_a: assert property (@(posedge mclk) disable iff (!rstn)
		fail_seen_s |-> standby_after_s)
		else $error("Power fail did not force standby");

	batt_block_a: assert property (@(posedge mclk) disable iff (!rstn)
		(!running && !batt_ok) |=> !running)
		else $error("Left standby with battery low");

	batt_fiq_a: assert property (@(posedge mclk) disable iff (!rstn)
		(running && $fell(batt_ok)) |=> req_r.fast_irq)
		else $error("Battery fall gave no fast request");

	media_fiq_a: assert property (@(posedge mclk) disable iff (!rstn)
		(running && !media_ok) |=> req_r.fast_irq)
		else $error("Media change gave no fast request");

	ext_fiq_a: assert property (@(posedge mclk) disable iff (!rstn)
		(running && !ext_fast_irq_n) |=> req_r.fast_irq)
		else $error("External fast request lost");

	gen_irq_a: assert property (@(posedge mclk) disable iff (!rstn)
		running |=> req_r.normal_irq == ~$past(ext_general_irq_n))
		else $error("General request mismatch");

	run_pin_a: assert property (@(posedge mclk) disable iff (!rstn)
		run_r == running)
		else $error("Run output disagrees with state");

	boot_strap_a: assert property (@(posedge mclk) disable iff (!rstn)
		strap_done_r |=> $stable(boot_rom_select_n))
		else $error("Boot select changed after strap");

	media_filt_a: assert property (@(posedge mclk) disable iff (!rstn)
		$fell(media_ok) |-> $past(media_change_irq_n, 1) == 1'b0)
		else $error("Media filter fell without low input");

	sequence wake_ok_s;
		!running && wake_req && batt_ok && pfail_ok;
	endsequence
	sequence run_next_s;
		##1 (running && run_r);
	endsequence

	wake_run_a: assert property (@(posedge mclk) disable iff (!rstn)
		wake_ok_s |-> run_next_s)
		else $error("Wake request did not start the system");

	sleep_req_a: assert property (@(posedge mclk) disable iff (!rstn)
		(running && standby_req) |=> !run_r)
		else $error("Standby request did not stop the system");

	enter_req_a: assert property (@(posedge mclk) disable iff (!rstn)
		!pfail_ok |=> req_r.enter_standby)
		else $error("Power fail gave no standby request");

	leave_block_a: assert property (@(posedge mclk) disable iff (!rstn)
		(!running && !batt_ok) |=> req_r.leave_blocked)
		else $error("Blocked wakeup not reported");

	quiet_standby_a: assert property (@(posedge mclk) disable iff (!rstn)
		!running |=> (!req_r.fast_irq && req_r.normal_irq == 2'b00))
		else $error("Request raised in standby");

	fiq_cause_a: assert property (@(posedge mclk) disable iff (!rstn)
		(running && media_ok && ext_fast_irq_n && !batt_fall) |=> !req_r.fast_irq)
		else $error("Fast request without a cause");

	strap_value_a: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(strap_done_r) |->
			boot_rom_select_n == $past(media_change_irq_n, 1))
		else $error("Boot select not taken from strap pin");

	supply_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
		$changed(external_supply_sense_n) |=>
			on_external_supply_r == ~$past(external_supply_sense_n, 1))
		else $error("Supply flag does not follow sense pin");
endmodule

// ===== sim/eapi_board_model.sv
`timescale 1ns/100ps
module eapi_board_model (
	input  wire logic mclk,
	output logic      media_change_irq_n,
	output logic      ext_fast_irq_n,
	output logic [1:0] ext_general_irq_n,
	output logic      power_fail_n,
	output logic      main_battery_good,
	output logic      external_supply_sense_n
);
	logic on_ext_r;
	initial
	begin
		{media_change_irq_n, ext_fast_irq_n, ext_general_irq_n} = 4'hf;
		{power_fail_n, main_battery_good, on_ext_r} = 3'h6;
	end
	assign external_supply_sense_n = ~on_ext_r;
	// Bits: media, fast, gen1, gen0, power fail, battery, on supply
	task automatic put(input logic [6:0] v);
		@(posedge mclk);
		{media_change_irq_n, ext_fast_irq_n, ext_general_irq_n} <= v[6:3];
		{power_fail_n, main_battery_good, on_ext_r} <= v[2:0];
	endtask
endmodule

// ===== sim/event_and_power_inputs_bench.sv
`timescale 1ns/100ps
module event_and_power_inputs_bench;
	localparam int H = int'(eapi_pkg::DEGLITCH_CYCLES);
	logic                mclk;
	logic                rstn;
	logic                wake_req;
	logic                standby_req;
	logic                med_n;
	logic                fiq_n;
	logic                pf_n;
	logic                bat;
	logic                sup_n;
	logic [1:0]          gen_n;
	eapi_pkg::eapi_req_t req;
	logic                run;
	logic                boot_n;
	logic                on_ext;
	int                  mismatches = 0;
	int                  n_checks = 0;
	int                  cyc = 0;
	int                  c;
	eapi_board_model board (
		.mclk                    (mclk),
		.media_change_irq_n      (med_n),
		.ext_fast_irq_n          (fiq_n),
		.ext_general_irq_n       (gen_n),
		.power_fail_n            (pf_n),
		.main_battery_good       (bat),
		.external_supply_sense_n (sup_n)
	);
	eapi_top #(.HOLD(H)) dut (
		.mclk                    (mclk),
		.rstn                    (rstn),
		.media_change_irq_n      (med_n),
		.ext_fast_irq_n          (fiq_n),
		.ext_general_irq_n       (gen_n),
		.power_fail_n            (pf_n),
		.main_battery_good       (bat),
		.external_supply_sense_n (sup_n),
		.wake_req                (wake_req),
		.standby_req             (standby_req),
		.req_r                   (req),
		.run_r                   (run),
		.boot_rom_select_n       (boot_n),
		.on_external_supply_r    (on_ext)
	);
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_gen(input logic [1:0] g, input logic [1:0] e);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Pulses must be caught in the cycle they stand
	task automatic fast_count(input int n, input int e);
		c = 0;
		repeat (n)
		begin
			settle(1);
			c += int'(req.fast_irq === 1'b1);
		end
		chk(c[7:0], e[7:0]);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	// ==========
	// Scenarios
	task automatic t_boot();
		board.put(7'h3e);
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		settle(2);
		chk_bit(boot_n, 1'b0);
		chk_bit(run, 1'b0);
		chk_bit(on_ext, 1'b0);
		board.put(7'h7e);
		settle(H + 3);
		@(posedge mclk);
		wake_req <= 1'b1;
		settle(3);
		chk_bit(run, 1'b1);
		@(posedge mclk);
		wake_req <= 1'b0;
	endtask
	task automatic t_irq();
		board.put(7'h5e);
		settle(3);
		chk_bit(req.fast_irq, 1'b1);
		for (int i = 0; i < 2; i++)
		begin
			board.put(7'h7e & ~(7'h08 << i));
			settle(3);
			chk_gen(req.normal_irq, 2'h1 << i);
		end
		board.put(7'h3e);
		repeat (H - 2) @(posedge mclk);
		board.put(7'h7e);
		fast_count(8, 0);
		board.put(7'h3e);
		settle(H + 3);
		chk_bit(req.fast_irq, 1'b1);
		board.put(7'h7e);
		settle(H + 3);
		board.put(7'h7c);
		fast_count(12, 1);
	endtask
	task automatic t_power();
		board.put(7'h78);
		settle(H + 3);
		chk_bit(run, 1'b0);
		chk_bit(req.enter_standby, 1'b1);
		board.put(7'h7c);
		settle(H + 3);
		@(posedge mclk);
		wake_req <= 1'b1;
		settle(4);
		chk_bit(run, 1'b0);
		board.put(7'h44);
		settle(3);
		chk_bit(run, 1'b0);
		chk_bit(req.leave_blocked, 1'b1);
		chk_bit(req.fast_irq, 1'b0);
		chk_gen(req.normal_irq, 2'h0);
		board.put(7'h7f);
		settle(H + 3);
		chk_bit(run, 1'b1);
		chk_bit(req.leave_blocked, 1'b0);
		chk_bit(on_ext, 1'b1);
	endtask
	// Software standby request, then supply sense released
	task automatic t_sleep();
		@(posedge mclk);
		wake_req    <= 1'b0;
		standby_req <= 1'b1;
		settle(2);
		chk_bit(run, 1'b0);
		chk_bit(req.enter_standby, 1'b0);
		@(posedge mclk);
		standby_req <= 1'b0;
		board.put(7'h7e);
		settle(2);
		chk_bit(on_ext, 1'b0);
	endtask
	// Reset in mid-run with the strap pin high
	task automatic t_rerun();
		@(posedge mclk);
		wake_req <= 1'b1;
		settle(2);
		chk_bit(run, 1'b1);
		@(posedge mclk);
		rstn     <= 1'b0;
		wake_req <= 1'b0;
		settle(1);
		chk_bit(run, 1'b0);
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		settle(2);
		chk_bit(boot_n, 1'b1);
		chk_bit(run, 1'b0);
		chk_bit(req.fast_irq, 1'b0);
	endtask
	initial
	begin
		{rstn, wake_req, standby_req} = 3'h0;
		t_boot();
		t_irq();
		t_power();
		t_sleep();
		t_rerun();
		wrap_up();
	end
endmodule
